// [i2cm_master.sv]
// Two-wire bus master with APB register access.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "i2cm_defs.svh"
module i2cm_master
    import i2cm_pkg::*;
#(
    parameter int RELOAD_W = 7
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bus clock line
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // Bus data line
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Event outputs
    output logic event_done_irq,
    output logic bus_collision_irq
);
    logic [7:0] serial_control_a_reg, serial_control_a_next;
    logic [7:0] serial_control_b_reg, serial_control_b_next;
    logic [1:0] status_cfg_reg, status_cfg_next;
    logic [7:0] bit_rate_reload_reg, bit_rate_reload_next;
    logic [7:0] tx_rx_buffer_reg, tx_rx_buffer_next;
    logic [7:0] shift_register_reg, shift_register_next;
    logic [1:0] flags_reg, flags_next;
    logic [1:0] enables_reg, enables_next;
    logic [6:0] own_addr_reg, own_addr_next;
    logic buffer_full_flag_reg, buffer_full_flag_next;
    logic rw_reg, rw_next;
    logic da_reg, da_next;
    logic p_reg, p_next;
    logic s_reg, s_next;
    logic ua_reg, ua_next;
    logic ten_bit_reg, ten_bit_next;
    logic first_byte_reg, first_byte_next;
    logic receiving_reg, receiving_next;
    i2cm_state_t state_reg, state_next;
    logic [1:0] phase_reg, phase_next;
    logic [3:0] bitn_reg, bitn_next;
    logic sda_drv_reg, sda_drv_next;
    logic scl_drv_reg, scl_drv_next;
    logic sda_d_reg, scl_d_reg;
    logic [31:0] prdata_next;
    logic pready_next;
    logic pslverr_next;
    logic tick;
    logic port_enable;
    logic busy;
    logic access;
    logic wr;
    logic sda_rise_hi, sda_fall_hi;
    logic [7:0] status_view;

    // Decode of one register offset, used for reads and writes alike.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign port_enable = serial_control_a_reg[`I2CM_CA_EN];
    assign busy = (|serial_control_b_reg[4:0]) | rw_reg;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign sda_fall_hi = scl_in & scl_d_reg & sda_d_reg & !sda_in;
    assign sda_rise_hi = scl_in & scl_d_reg & !sda_d_reg & sda_in;
    assign status_view = {status_cfg_reg, da_reg, p_reg, s_reg, rw_reg,
                          ua_reg, buffer_full_flag_reg};

    i2cm_quarter_tick #(.WIDTH(RELOAD_W)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(port_enable & busy & (state_reg != I2CM_IDLE)),
        .reload(bit_rate_reload_reg[RELOAD_W-1:0]),
        .tick(tick)
    );

    // Register file and bus engine share one next-state process.
    always_comb begin
        serial_control_a_next = serial_control_a_reg;
        serial_control_b_next = serial_control_b_reg;
        status_cfg_next = status_cfg_reg;
        bit_rate_reload_next = bit_rate_reload_reg;
        tx_rx_buffer_next = tx_rx_buffer_reg;
        shift_register_next = shift_register_reg;
        flags_next = flags_reg;
        enables_next = enables_reg;
        own_addr_next = own_addr_reg;
        buffer_full_flag_next = buffer_full_flag_reg;
        rw_next = rw_reg;
        da_next = da_reg;
        p_next = p_reg;
        s_next = s_reg;
        ua_next = ua_reg;
        ten_bit_next = ten_bit_reg;
        first_byte_next = first_byte_reg;
        receiving_next = receiving_reg;
        state_next = state_reg;
        phase_next = phase_reg;
        bitn_next = bitn_reg;
        sda_drv_next = sda_drv_reg;
        scl_drv_next = scl_drv_reg;
        prdata_next = 32'h0000_0000;
        pready_next = 1'b0;
        pslverr_next = 1'b0;

        // Software side: one wait state, answer in the second access cycle.
        if (access && !pready) begin
            pready_next = 1'b1;
            if (!pwrite) begin
                if (hit(paddr, `I2CM_OFF_CTRL_A)) begin
                    prdata_next[7:0] = serial_control_a_reg;
                end else if (hit(paddr, `I2CM_OFF_CTRL_B)) begin
                    prdata_next[7:0] = serial_control_b_reg;
                end else if (hit(paddr, `I2CM_OFF_STATUS)) begin
                    prdata_next[7:0] = status_view;
                end else if (hit(paddr, `I2CM_OFF_RELOAD)) begin
                    prdata_next[7:0] = bit_rate_reload_reg;
                end else if (hit(paddr, `I2CM_OFF_BUFFER)) begin
                    prdata_next[7:0] = tx_rx_buffer_reg;
                end else if (hit(paddr, `I2CM_OFF_FLAGS)) begin
                    prdata_next[1:0] = flags_reg;
                end else if (hit(paddr, `I2CM_OFF_ENABLES)) begin
                    prdata_next[1:0] = enables_reg;
                end else if (hit(paddr, `I2CM_OFF_ADDR)) begin
                    prdata_next[6:0] = own_addr_reg;
                end else begin
                    pslverr_next = 1'b1;
                end
            end
        end
        if (wr && pready) begin
            if (hit(paddr, `I2CM_OFF_CTRL_A)) begin
                // port enable; collision bit only clears by write.
                serial_control_a_next = {serial_control_a_reg[7] & pwdata[7],
                                         pwdata[6:0]};
            end else if (hit(paddr, `I2CM_OFF_CTRL_B)) begin
                // launch bits taken only when idle
                if (!busy) begin
                    serial_control_b_next = pwdata[7:0];
                    if (|pwdata[4:0]) begin
                        phase_next = 2'd0;
                    end
                end else begin
                    serial_control_b_next[7:5] = pwdata[7:5];
                end
            end else if (hit(paddr, `I2CM_OFF_STATUS)) begin
                status_cfg_next = pwdata[7:6];
            end else if (hit(paddr, `I2CM_OFF_RELOAD)) begin
                bit_rate_reload_next = pwdata[7:0];
            end else if (hit(paddr, `I2CM_OFF_BUFFER)) begin
                if (busy || state_reg != I2CM_IDLE) begin
                    serial_control_a_next[`I2CM_CA_WRITE_COLLISION] = 1'b1;
                end else begin
                    // buffer write launches a byte write
                    tx_rx_buffer_next = pwdata[7:0];
                    shift_register_next = pwdata[7:0];
                    buffer_full_flag_next = 1'b1;
                    rw_next = 1'b1;
                    receiving_next = 1'b0;
                    bitn_next = 4'd0;
                    phase_next = 2'd0;
                    state_next = I2CM_BIT;
                    // ten-bit header byte marks a pending low address
                    if (first_byte_reg) begin
                        ten_bit_next = pwdata[7:3] == 5'b11110;
                        ua_next = pwdata[7:3] == 5'b11110;
                    end
                end
            end else if (hit(paddr, `I2CM_OFF_FLAGS)) begin
                flags_next = flags_reg & ~pwdata[1:0];
            end else if (hit(paddr, `I2CM_OFF_ENABLES)) begin
                enables_next = pwdata[1:0];
            end else if (hit(paddr, `I2CM_OFF_ADDR)) begin
                own_addr_next = pwdata[6:0];
            end
        end
        if (!pwrite && access && pready && hit(paddr, `I2CM_OFF_BUFFER)) begin
            buffer_full_flag_next = 1'b0;
        end

        // Condition watch on the bus.
        if (sda_fall_hi) begin
            s_next = 1'b1;
            p_next = 1'b0;
            first_byte_next = 1'b1;
        end
        if (sda_rise_hi) begin
            p_next = 1'b1;
            s_next = 1'b0;
        end

        // Launch from idle: pick the event in priority order.
        if (state_reg == I2CM_IDLE && port_enable) begin
            if (serial_control_b_reg[`I2CM_CB_START]) begin
                state_next = I2CM_START;
            end else if (serial_control_b_reg[`I2CM_CB_RESTART]) begin
                state_next = I2CM_RSTART;
            end else if (serial_control_b_reg[`I2CM_CB_STOP]) begin
                state_next = I2CM_STOP;
            end else if (serial_control_b_reg[`I2CM_CB_RECV]) begin
                receiving_next = 1'b1;
                bitn_next = 4'd0;
                state_next = I2CM_BIT;
            end else if (serial_control_b_reg[`I2CM_CB_ACKLAUNCH]) begin
                state_next = I2CM_ACKOUT;
            end
        end else if (tick) begin
            phase_next = phase_reg + 2'd1;
            case (state_reg)
                I2CM_START, I2CM_RSTART: begin
                    // data falls with clock high; restart first
                    // raises data and clock from the held low clock.
                    case (phase_reg)
                        2'd0: sda_drv_next = 1'b1;
                        2'd1: scl_drv_next = 1'b1;
                        2'd2: sda_drv_next = 1'b0;
                        default: begin
                            scl_drv_next = 1'b0;
                            serial_control_b_next[1:0] = 2'b00;
                            flags_next[`I2CM_FL_DONE] = 1'b1;
                            state_next = I2CM_IDLE;
                        end
                    endcase
                end
                I2CM_STOP: begin
                    case (phase_reg)
                        2'd0: sda_drv_next = 1'b0;
                        2'd1: scl_drv_next = 1'b1;
                        2'd2: sda_drv_next = 1'b1;
                        default: begin
                            serial_control_b_next[`I2CM_CB_STOP] = 1'b0;
                            flags_next[`I2CM_FL_DONE] = 1'b1;
                            da_next = 1'b0;
                            state_next = I2CM_IDLE;
                        end
                    endcase
                end
                I2CM_BIT, I2CM_ACKB, I2CM_ACKOUT: begin
                    case (phase_reg)
                        2'd0: begin
                            // data set up in clock low
                            if (state_reg == I2CM_ACKOUT) begin
                                sda_drv_next =
                                    serial_control_b_reg[`I2CM_CB_ACKDATA];
                            end else if (state_reg == I2CM_ACKB ||
                                         receiving_reg) begin
                                sda_drv_next = 1'b1;
                            end else begin
                                sda_drv_next = shift_register_reg[7];
                            end
                        end
                        2'd1: scl_drv_next = 1'b1;
                        2'd2: begin
                            // released one but low while clock high
                            if (sda_drv_reg && !sda_in &&
                                state_reg == I2CM_BIT && !receiving_reg) begin
                                flags_next[`I2CM_FL_BCOL] = 1'b1;
                                serial_control_b_next[4:0] = 5'b00000;
                                rw_next = 1'b0;
                                scl_drv_next = 1'b1;
                                sda_drv_next = 1'b1;
                                state_next = I2CM_IDLE;
                            end else if (state_reg == I2CM_BIT) begin
                                shift_register_next =
                                    {shift_register_reg[6:0], sda_in};
                            end else if (state_reg == I2CM_ACKB) begin
                                serial_control_b_next[6] = sda_in;
                            end
                        end
                        default: begin
                            scl_drv_next = 1'b0;
                            bitn_next = bitn_reg + 4'd1;
                            if (state_reg == I2CM_ACKOUT) begin
                                serial_control_b_next[`I2CM_CB_ACKLAUNCH] =
                                    1'b0;
                                flags_next[`I2CM_FL_DONE] = 1'b1;
                                state_next = I2CM_IDLE;
                            end else if (state_reg == I2CM_ACKB) begin
                                rw_next = 1'b0;
                                flags_next[`I2CM_FL_DONE] = 1'b1;
                                first_byte_next = 1'b0;
                                da_next = !first_byte_reg;
                                if (!ten_bit_reg) begin
                                    ua_next = 1'b0;
                                end
                                ten_bit_next = 1'b0;
                                state_next = I2CM_IDLE;
                            end else if (bitn_reg == 4'd7) begin
                                if (receiving_reg) begin
                                    tx_rx_buffer_next = shift_register_reg;
                                    buffer_full_flag_next = 1'b1;
                                    serial_control_b_next[`I2CM_CB_RECV] =
                                        1'b0;
                                    flags_next[`I2CM_FL_DONE] = 1'b1;
                                    da_next = 1'b1;
                                    state_next = I2CM_IDLE;
                                end else begin
                                    buffer_full_flag_next = 1'b0;
                                    state_next = I2CM_ACKB;
                                end
                            end
                        end
                    endcase
                end
                default: state_next = I2CM_IDLE;
            endcase
        end
        if (!port_enable) begin
            state_next = I2CM_IDLE;
            sda_drv_next = 1'b1;
            scl_drv_next = 1'b1;
            rw_next = 1'b0;
            serial_control_b_next[4:0] = 5'b00000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_a_reg <= `I2CM_RESET_BYTE;
            serial_control_b_reg <= `I2CM_RESET_BYTE;
            status_cfg_reg <= 2'b00;
            bit_rate_reload_reg <= `I2CM_RELOAD_RESET;
            tx_rx_buffer_reg <= `I2CM_RESET_BYTE;
            shift_register_reg <= `I2CM_RESET_BYTE;
            flags_reg <= 2'b00;
            enables_reg <= 2'b00;
            own_addr_reg <= 7'h00;
            buffer_full_flag_reg <= 1'b0;
            rw_reg <= 1'b0;
            da_reg <= 1'b0;
            p_reg <= 1'b0;
            s_reg <= 1'b0;
            ua_reg <= 1'b0;
            ten_bit_reg <= 1'b0;
            first_byte_reg <= 1'b0;
            receiving_reg <= 1'b0;
            state_reg <= I2CM_IDLE;
            phase_reg <= 2'd0;
            bitn_reg <= 4'd0;
            sda_drv_reg <= 1'b1;
            scl_drv_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            event_done_irq <= 1'b0;
            bus_collision_irq <= 1'b0;
        end else begin
            serial_control_a_reg <= serial_control_a_next;
            serial_control_b_reg <= serial_control_b_next;
            status_cfg_reg <= status_cfg_next;
            bit_rate_reload_reg <= bit_rate_reload_next;
            tx_rx_buffer_reg <= tx_rx_buffer_next;
            shift_register_reg <= shift_register_next;
            flags_reg <= flags_next;
            enables_reg <= enables_next;
            own_addr_reg <= own_addr_next;
            buffer_full_flag_reg <= buffer_full_flag_next;
            rw_reg <= rw_next;
            da_reg <= da_next;
            p_reg <= p_next;
            s_reg <= s_next;
            ua_reg <= ua_next;
            ten_bit_reg <= ten_bit_next;
            first_byte_reg <= first_byte_next;
            receiving_reg <= receiving_next;
            state_reg <= state_next;
            phase_reg <= phase_next;
            bitn_reg <= bitn_next;
            sda_drv_reg <= sda_drv_next;
            scl_drv_reg <= scl_drv_next;
            sda_d_reg <= sda_in;
            scl_d_reg <= scl_in;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            // Open drain: only a low is ever driven.
            scl_out <= 1'b0;
            scl_oe <= !scl_drv_next;
            sda_out <= 1'b0;
            sda_oe <= !sda_drv_next;
            // done flag gated by its enable
            event_done_irq <= flags_next[0] & enables_next[0];
            bus_collision_irq <= flags_next[1] & enables_next[1];
        end
    end
endmodule

// [i2cm_defs.svh]
// Register offsets, field positions, reset values and timing counts.
// Contract
// - Master starts transfers and shifts bytes most significant bit first.
// - A ninth clock follows each byte; sender releases data, receiver answers.
// - Low in ninth slot is acknowledge, high is not-acknowledge.
// - Data changes only while clock is low, except start and stop.
// - Start: data falls while clock stays high.
// - Stop: data rises while clock is high.
// - Repeated start is a start without a preceding stop.
// - Master makes every clock; quarter bit period is reload plus one cycles; only the low seven reload bits reach the divider.
// - Port enable bit five of control A hands pins to the module.
// - Status holds slew-rate and input-threshold select settings.
// - Status shows data/address, stop, start, read/write, update address, full.
// - Control B bits zero to three launch start, restart, stop, receive.
// - Acknowledge: write level to bit five, then set launch bit four.
// - During acknowledge clock the receiver holds data low throughout clock high.
// - Event-done and bus-collision flags each have an enable bit.
// - Start and stop are detected in hardware and flagged.
// - Seven- and ten-bit address formats are supported.
// - Buffer write launches a byte write; read/write bit stays set meanwhile.
// - Buffer write while busy sets write collision, buffer unchanged.
// - Released one sampled low while clock high: bus collision, go idle.
// - Event-done flag is set at each event completion; software clears it.
`ifndef I2CM_DEFS_SVH
`define I2CM_DEFS_SVH
`define I2CM_OFF_CTRL_A 8'h00
`define I2CM_OFF_CTRL_B 8'h04
`define I2CM_OFF_STATUS 8'h08
`define I2CM_OFF_RELOAD 8'h0C
`define I2CM_OFF_BUFFER 8'h10
`define I2CM_OFF_FLAGS 8'h14
`define I2CM_OFF_ENABLES 8'h18
`define I2CM_OFF_ADDR 8'h1C
`define I2CM_CA_WRITE_COLLISION 7
`define I2CM_CA_EN 5
`define I2CM_CB_ACKDATA 5
`define I2CM_CB_ACKLAUNCH 4
`define I2CM_CB_RECV 3
`define I2CM_CB_STOP 2
`define I2CM_CB_RESTART 1
`define I2CM_CB_START 0
`define I2CM_ST_SLEW 7
`define I2CM_ST_SMB 6
`define I2CM_ST_DA 5
`define I2CM_ST_P 4
`define I2CM_ST_S 3
`define I2CM_ST_RW 2
`define I2CM_ST_UA 1
`define I2CM_ST_BF 0
`define I2CM_FL_DONE 0
`define I2CM_FL_BCOL 1
`define I2CM_RESET_BYTE 8'h00
`define I2CM_RELOAD_RESET 8'h7F
`endif

// [i2cm_pkg.sv]
// Types shared by the two-wire master files.
package i2cm_pkg;
    typedef enum logic [6:0] {
        I2CM_IDLE = 7'b000_0001,
        I2CM_START = 7'b000_0010,
        I2CM_STOP = 7'b000_0100,
        I2CM_BIT = 7'b000_1000,
        I2CM_ACKB = 7'b001_0000,
        I2CM_ACKOUT = 7'b010_0000,
        I2CM_RSTART = 7'b100_0000
    } i2cm_state_t;
endpackage

// [i2cm_quarter_tick.sv]
// Divider making one quarter-bit enable pulse every reload plus one cycles.
`timescale 1ns/1ps
module i2cm_quarter_tick #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic [WIDTH-1:0] reload,
    // Enable out
    output logic tick
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;
    logic tick_next;

    always_comb begin
        tick_next = 1'b0;
        cnt_next = cnt_reg;
        if (!run) begin
            cnt_next = '0;
        end else if (cnt_reg >= reload) begin
            cnt_next = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end
endmodule

// [i2cm_properties.sv]
// Checker for the register port and bus pins of the two-wire master.
`timescale 1ns/1ps
module i2cm_properties (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Bus pins
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup_access;
        psel && !penable ##1 psel && penable;
    endsequence
    property p_access_answer; s_setup_access |=> pready; endproperty
    a_access_answer: assert property (p_access_answer) else $error("no answer");
    property p_pready_pulse; pready |=> !pready; endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("long pready");
    property p_ready_cause; $rose(pready) |-> $past(psel && penable); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("stray pready");
    property p_err_ready; pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("bad error");
    property p_rdata_idle; !pready |-> prdata == 32'h0000_0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray data");
    property p_reset_idle; $rose(presetn) |-> !scl_oe && !sda_oe; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("lines held");
    property p_open_drain; !scl_out && !sda_out; endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven");
    property p_start_hold; $rose(sda_oe) && !scl_oe |=> !scl_oe; endproperty
    a_start_hold: assert property (p_start_hold) else $error("bad start");
    property p_stop_shape; $fell(sda_oe) && !scl_oe |-> $past(!scl_oe);
    endproperty
    a_stop_shape: assert property (p_stop_shape) else $error("bad stop");
endmodule
bind i2cm_master i2cm_properties u_props (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .prdata, .scl_out, .scl_oe, .sda_out, .sda_oe);

// [i2cm_slave_model.sv]
// Behavioural slave that acknowledges each byte written to it unless nack is high.
`timescale 1ns/1ps
module i2cm_slave_model (
    // Bus lines
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull,
    // Behaviour
    input wire logic nack,
    // Observation
    output logic [7:0] last_byte
);
    int cnt = 0;
    logic [7:0] sh = 8'h00;
    initial sda_pull = 1'b0;
    initial last_byte = 8'h00;
    always @(negedge sda) if (scl) cnt = 0;
    always @(posedge sda) if (scl) cnt = 0;
    always @(posedge scl) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        cnt = cnt + 1;
    end
    always @(negedge scl) begin
        if (cnt == 8) last_byte = sh;
        sda_pull = (cnt == 8) && !nack;
        if (cnt == 9) cnt = 0;
    end
endmodule

// [testbench.sv]
// Self-checking bench for the two-wire master.
`timescale 1ns/1ps
`include "i2cm_defs.svh"
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, scl_oe, sda_oe, sda_pull, done_irq;
    logic bcol_irq, nack = 1'b0, jam = 1'b0;
    logic [7:0] seen, rl;
    logic [63:0] expq[$];
    logic [63:0] ent;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    wire scl = !scl_oe;
    // A second master can jam data low to provoke arbitration loss.
    wire sda = !(sda_oe || sda_pull || jam);
    always #2 pclk = !pclk;
    i2cm_master dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .scl_out(),
        .scl_oe, .sda_in(sda), .sda_out(), .sda_oe,
        .event_done_irq(done_irq), .bus_collision_irq(bcol_irq));
    i2cm_slave_model slave (.scl, .sda, .sda_pull, .nack,
        .last_byte(seen));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        expq.push_back({m, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task wait_clear(input logic [7:0] a, input int b);
        do rdx(a, 32'h0000_0000, 32'h0000_0000); while (rd[b] !== 1'b0);
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            ent = expq.pop_front();
            chk("prdata", ent[31:0], prdata & ent[63:32]);
            chk("pslverr", {31'h0, paddr > `I2CM_OFF_ADDR},
                {31'h0, pslverr});
        end
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(91089));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) rdx(8'(4 * i), i == 3 ? 32'h7F : 0, '1);
        $display("test reset values done");
        rl = 8'($urandom_range(3, 1));
        apb(1'b1, `I2CM_OFF_RELOAD, {24'h0, rl});
        rdx(`I2CM_OFF_RELOAD, {24'h0, rl}, 32'hFF);
        apb(1'b1, `I2CM_OFF_ENABLES, 32'h3);
        chk("lines", 32'h3, {30'h0, scl, sda});
        apb(1'b1, `I2CM_OFF_CTRL_A, 32'h20);
        apb(1'b1, `I2CM_OFF_CTRL_B, 32'h1);
        wait_clear(`I2CM_OFF_CTRL_B, 0);
        chk("sda", 32'h0, {31'h0, sda});
        chk("done_irq", 32'h1, {31'h0, done_irq});
        rdx(`I2CM_OFF_FLAGS, 32'h1, 32'h1);
        apb(1'b1, `I2CM_OFF_FLAGS, 32'h1);
        $display("test start done");
        apb(1'b1, `I2CM_OFF_BUFFER, 32'hA5);
        apb(1'b1, `I2CM_OFF_BUFFER, 32'h3C);
        rdx(`I2CM_OFF_CTRL_A, 32'hA0, 32'hFF);
        wait_clear(`I2CM_OFF_STATUS, 2);
        chk("byte", 32'hA5, {24'h0, seen});
        rdx(`I2CM_OFF_CTRL_B, 32'h0, 32'h40);
        apb(1'b1, `I2CM_OFF_CTRL_A, 32'h20);
        apb(1'b1, `I2CM_OFF_CTRL_B, 32'h2);
        wait_clear(`I2CM_OFF_CTRL_B, 1);
        nack <= 1'b1;
        apb(1'b1, `I2CM_OFF_BUFFER, 32'h5A);
        wait_clear(`I2CM_OFF_STATUS, 2);
        rdx(`I2CM_OFF_CTRL_B, 32'h40, 32'h40);
        apb(1'b1, `I2CM_OFF_CTRL_B, 32'h8);
        wait_clear(`I2CM_OFF_CTRL_B, 3);
        rdx(`I2CM_OFF_BUFFER, 32'hFF, 32'hFF);
        apb(1'b1, `I2CM_OFF_CTRL_B, 32'h10);
        wait_clear(`I2CM_OFF_CTRL_B, 4);
        chk("ack", 32'h0, {31'h0, sda});
        apb(1'b1, `I2CM_OFF_CTRL_B, 32'h4);
        wait_clear(`I2CM_OFF_CTRL_B, 2);
        chk("lines", 32'h3, {30'h0, scl, sda});
        $display("test bus events done");
        jam <= 1'b1;
        apb(1'b1, `I2CM_OFF_BUFFER, 32'h80);
        wait_clear(`I2CM_OFF_STATUS, 2);
        chk("bcol_irq", 32'h1, {31'h0, bcol_irq});
        jam <= 1'b0;
        rdx(`I2CM_OFF_FLAGS, 32'h2, 32'h2);
        $display("test collision done");
        stop_test();
    end
endmodule
